// >>> design/nfc_host.v
// Purpose: Host controller driving a parallel NOR flash by its pins
// Assumes: Wishbone classic slave, 32-bit data, 250 MHz clk_sys
// Notes:   Software sequences commands; block times pin cycles
// Behaviour
// - Wait 50 ns after reset release
// - Toggle reads by chip select or enable
// - Protect address encodings on bits 6,1,0
// - Hold unprotect level 4 us before write
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
`include "nfc_defines.vh"
module nfc_host
#(
    parameter [23:0] READY_CYC = `NFC_T_READY_CYC,
    parameter [23:0] RSP_CYC   = `NFC_T_RSP_CYC
)
(
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg         flashCeN,
    output reg         flashOeN,
    output reg         flashWeN,
    output reg         flashResetN,
    output reg         unprotLevelEn,
    output reg  [19:0] flashAddr,
    output reg  [15:0] flashDqOut,
    output reg         flashDqOe,
    input  wire [15:0] flashDqIn,
    input  wire        readyBusyN
);
    localparam [3:0] ST_IDLE  = 4'h0;
    localparam [3:0] ST_RST   = 4'h1;
    localparam [3:0] ST_RREC  = 4'h2;
    localparam [3:0] ST_RHOLD = 4'h3;
    localparam [3:0] ST_VID   = 4'h4;
    localparam [3:0] ST_WR    = 4'h5;
    localparam [3:0] ST_WREC  = 4'h6;
    localparam [3:0] ST_RD    = 4'h7;
    localparam [3:0] ST_RDEND = 4'h8;
    localparam [3:0] ST_BUSYW = 4'h9;
    localparam [3:0] ST_TG1   = 4'ha;
    localparam [3:0] ST_TG2   = 4'hb;
    localparam [3:0] ST_TG3   = 4'hc;

    reg  [3:0]  state_r;
    reg  [3:0]  state_nxt;
    reg  [7:0]  ctrl_r;
    reg  [19:0] addr_r;
    reg  [15:0] wdata_r;
    reg  [15:0] rdata_r;
    reg  [15:0] tog1_r;
    reg         togDone_r;
    reg         togErr_r;
    reg         eraseKeep_r;
    reg         midAlgo_r;
    reg         tLoad;
    reg  [23:0] tValue;
    wire        tDone;
    wire        rbSync;
    wire [15:0] dqSync;
    wire        wbReq;
    wire        busy;

    assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign busy  = (state_r != ST_IDLE);

    // Pin inputs pass two flops before use
    nfc_sync u_syncRb
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .din     (readyBusyN),
        .dout    (rbSync)
    );
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1)
        begin : g_dq
            nfc_sync u_syncDq
            (
                .clk_sys (clk_sys),
                .rst     (rst),
                .din     (flashDqIn[gi]),
                .dout    (dqSync[gi])
            );
        end
    endgenerate

    // One shared timer for every pin delay
    nfc_timer #(.W(24)) u_timer
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .load    (tLoad),
        .value   (tValue),
        .done    (tDone)
    );

    // Wishbone slave: one-cycle ack, unmapped reads zero
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            ctrl_r   <= 8'h0;
            addr_r   <= 20'h0;
            wdata_r  <= 16'h0;
        end
        else
        begin
            wb_ack_o <= wbReq;
            ctrl_r[`NFC_CTRL_GO] <= 1'b0; // Go is a self-clearing strobe
            if (wbReq && wb_we_i && wb_sel_i[0] && wb_adr_i == `NFC_REG_CTRL &&
                (!busy || (state_r == ST_BUSYW && wb_dat_i[`NFC_CTRL_RESET])))
                ctrl_r <= wb_dat_i[7:0];
            if (wbReq && wb_we_i && wb_adr_i == `NFC_REG_ADDR)
            begin
                if (wb_sel_i[0])
                    addr_r[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1])
                    addr_r[15:8] <= wb_dat_i[15:8];
                if (wb_sel_i[2])
                    addr_r[19:16] <= wb_dat_i[19:16];
            end
            if (wbReq && wb_we_i && wb_adr_i == `NFC_REG_WDATA)
            begin
                if (wb_sel_i[0])
                    wdata_r[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1])
                    wdata_r[15:8] <= wb_dat_i[15:8];
            end
            case (wb_adr_i)
                `NFC_REG_CTRL   : wb_dat_o <= {24'h0, 1'b0, ctrl_r[6:0]};
                `NFC_REG_ADDR   : wb_dat_o <= {12'h0, addr_r};
                `NFC_REG_WDATA  : wb_dat_o <= {16'h0, wdata_r};
                `NFC_REG_STATUS : wb_dat_o <= {rdata_r, 11'h0, eraseKeep_r, togErr_r,
                                               togDone_r, rbSync, busy};
                default         : wb_dat_o <= 32'h0;
            endcase
        end
    end

    // Sequencer next state and timer loads
    always @*
    begin
        state_nxt = state_r;
        tLoad     = 1'b0;
        tValue    = 24'h0;
        case (state_r)
            ST_IDLE, ST_BUSYW: // A reset order may cut a busy wait
            begin
                if (ctrl_r[`NFC_CTRL_GO])
                begin
                    tLoad = 1'b1;
                    if (ctrl_r[`NFC_CTRL_RESET])
                    begin
                        state_nxt = ST_RST;
                        tValue    = `NFC_T_RP_CYC;
                    end
                    else if (ctrl_r[`NFC_CTRL_UNPROT])
                    begin
                        state_nxt = ST_VID;
                        tValue    = RSP_CYC;
                    end
                    else if (ctrl_r[`NFC_CTRL_WRITE])
                    begin
                        state_nxt = ST_WR;
                        tValue    = `NFC_T_CYC_CYC;
                    end
                    else
                    begin
                        state_nxt = ST_RD;
                        tValue    = `NFC_T_CYC_CYC;
                    end
                end
                else if (rbSync)
                    state_nxt = ST_IDLE;
            end
            ST_RST:
            begin
                if (tDone)
                begin
                    state_nxt = ST_RREC;
                    tLoad     = 1'b1;
                    tValue    = midAlgo_r ? READY_CYC : `NFC_T_RP_CYC;
                end
            end
            ST_RREC:
            begin
                if (tDone)
                begin
                    state_nxt = ST_RHOLD;
                    tLoad     = 1'b1;
                    tValue    = `NFC_T_RH_CYC;
                end
            end
            ST_WR:
            begin
                if (tDone)
                begin
                    state_nxt = ST_WREC;
                    tLoad     = 1'b1;
                    tValue    = `NFC_T_BUSY_CYC;
                end
            end
            ST_WREC:
            begin
                if (tDone)
                    state_nxt = ST_BUSYW;
            end
            // Read strobes and toggle gaps step through consecutive codes
            ST_RD, ST_TG1, ST_TG2:
            begin
                if (tDone)
                begin
                    state_nxt = state_r + 4'h1;
                    tLoad     = 1'b1;
                    tValue    = `NFC_T_CYC_CYC;
                end
            end
            ST_RDEND:
            begin
                if (tDone)
                begin
                    tLoad  = ctrl_r[`NFC_CTRL_TOGGLE];
                    tValue = `NFC_T_CYC_CYC;
                    state_nxt = ctrl_r[`NFC_CTRL_TOGGLE] ? ST_TG1 : ST_IDLE;
                end
            end
            ST_VID, ST_RHOLD, ST_TG3:
            begin
                if (tDone)
                    state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Pin drive and status capture
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_r       <= ST_IDLE;
            flashCeN      <= 1'b1;
            flashOeN      <= 1'b1;
            flashWeN      <= 1'b1;
            flashResetN   <= 1'b0;
            unprotLevelEn <= 1'b0;
            flashAddr     <= 20'h0;
            flashDqOut    <= 16'h0;
            flashDqOe     <= 1'b0;
            rdata_r       <= 16'h0;
            tog1_r        <= 16'h0;
            togDone_r     <= 1'b0;
            togErr_r      <= 1'b0;
            eraseKeep_r   <= 1'b0;
            midAlgo_r     <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            flashResetN <= (state_nxt != ST_RST);
            flashCeN    <= 1'b1;
            flashOeN    <= 1'b1;
            flashWeN    <= 1'b1;
            flashDqOe   <= 1'b0;
            if (ctrl_r[`NFC_CTRL_GO])
            begin
                midAlgo_r <= ~rbSync;
                togDone_r <= 1'b0;
                // Protect selects drive bits 6,1,0 on top of address
                if (ctrl_r[`NFC_CTRL_SECT])
                    flashAddr <= {addr_r[19:7], ctrl_r[`NFC_CTRL_UNSEL], addr_r[5:2], 2'b10};
                else
                    flashAddr <= addr_r;
                flashDqOut <= wdata_r;
                if (ctrl_r[`NFC_CTRL_UNPROT])
                    unprotLevelEn <= 1'b1;
            end
            if (ctrl_r[`NFC_CTRL_GO] && ctrl_r[`NFC_CTRL_RESET])
                unprotLevelEn <= 1'b0;
            case (state_nxt)
                ST_WR:
                begin
                    flashCeN  <= 1'b0;
                    flashWeN  <= 1'b0;
                    flashDqOe <= 1'b1;
                end
                ST_RD, ST_TG1, ST_TG3:
                begin
                    flashCeN <= 1'b0;
                    flashOeN <= 1'b0;
                end
                // Toggle reads pulse either CE or OE
                ST_RDEND, ST_TG2:
                begin
                    flashCeN <= ctrl_r[`NFC_CTRL_USECE];
                    flashOeN <= ~ctrl_r[`NFC_CTRL_USECE];
                end
                default: flashCeN <= 1'b1;
            endcase
            // Data sampled at end of each read strobe
            if (state_r == ST_RD && tDone)
                rdata_r <= dqSync;
            if (state_r == ST_TG1 && tDone)
                tog1_r <= dqSync;
            // Main bit toggles on any address; erase bit only in suspended sector
            if (state_r == ST_TG3 && tDone)
            begin
                togDone_r   <= (rdata_r[6] == dqSync[6]) && (tog1_r[6] == dqSync[6]);
                togErr_r    <= dqSync[5];
                eraseKeep_r <= (tog1_r[2] != dqSync[2]);
                rdata_r     <= dqSync;
            end
        end
    end
endmodule // nfc_host

// >>> design/nfc_defines.vh
// Purpose: Constants for the NOR flash host controller
// Assumes: 250 MHz system clock, 4 ns period
// Notes:   Times in ns; cycle counts derived from them
`ifndef NFC_DEFINES_VH
`define NFC_DEFINES_VH
`define NFC_CLK_NS          4
// Register offsets on the Wishbone slave (byte addresses)
`define NFC_REG_CTRL        4'h0
`define NFC_REG_ADDR        4'h4
`define NFC_REG_WDATA       4'h8
`define NFC_REG_STATUS      4'hc
// Control register fields
`define NFC_CTRL_GO         0
`define NFC_CTRL_WRITE      1
`define NFC_CTRL_RESET      2
`define NFC_CTRL_UNPROT     3
`define NFC_CTRL_SECT       4
`define NFC_CTRL_UNSEL      5
`define NFC_CTRL_TOGGLE     6
`define NFC_CTRL_USECE      7
// Status register fields
`define NFC_ST_BUSY         0
`define NFC_ST_RDYBSY       1
`define NFC_ST_TOGDONE      2
`define NFC_ST_TOGERR       3
`define NFC_ST_EKEEP        4
// Timing in ns, counts in cycles
`define NFC_T_RP_NS         500
`define NFC_T_RP_CYC        24'h00007d
`define NFC_T_READY_NS      20000
`define NFC_T_READY_CYC     24'h001388
`define NFC_T_RH_NS         50
`define NFC_T_RH_CYC        24'h00000d
`define NFC_T_RSP_NS        4000
`define NFC_T_RSP_CYC       24'h0003e8
`define NFC_T_BUSY_NS       90
`define NFC_T_BUSY_CYC      24'h000017
`define NFC_T_CYC_NS        120
`define NFC_T_CYC_CYC       24'h00001e
`define NFC_T_ERASE_NS      700000000
`endif

// >>> design/nfc_sync.v
// Purpose: Two-flop synchroniser for a pin input
// Assumes: Single bit, asynchronous source
// Notes:   First flop feeds only the second
`timescale 1ns/10ps
module nfc_sync
(
    input  wire clk_sys,
    input  wire rst,
    input  wire din,
    output reg  dout
);
    reg meta_r;
    // Double register against metastability
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            meta_r <= 1'b0;
            dout   <= 1'b0;
        end
        else
        begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule // nfc_sync

// >>> design/nfc_timer.v
// Purpose: Loadable down-counter for pin timing
// Assumes: Load and count on clk_sys
// Notes:   done is high while count is zero
`timescale 1ns/10ps
module nfc_timer
#(
    parameter W = 16
)
(
    input  wire         clk_sys,
    input  wire         rst,
    input  wire         load,
    input  wire [W-1:0] value,
    output wire         done
);
    reg [W-1:0] cnt_r;
    // Reload wins over counting
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            cnt_r <= {W{1'b0}};
        else if (load)
            cnt_r <= value;
        else if (cnt_r != {W{1'b0}})
            cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
    end
    assign done = (cnt_r == {W{1'b0}});
endmodule // nfc_timer

// >>> sim/nfc_host_properties.sv
// Purpose: Port checks on the NOR flash host controller
// Assumes: One clock, rst async active high
// Notes:   Saturating counters give pin phases their spans
`timescale 1ns/10ps
module nfc_host_checker
#(
    parameter [23:0] READY_CYC = 24'h001388,
    parameter [23:0] RSP_CYC   = 24'h0003e8
)
(
    input wire clk_sys,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire flashOeN,
    input wire flashWeN,
    input wire flashResetN,
    input wire unprotLevelEn,
    input wire flashDqOe,
    input wire readyBusyN
);
    logic [7:0]  loCnt_r;
    logic [7:0]  hiCnt_r;
    logic [23:0] unCnt_r;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Power-up counts as a long reset pulse
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            loCnt_r <= 8'hff;
            hiCnt_r <= 8'hff;
            unCnt_r <= 24'h000000;
        end
        else
        begin
            loCnt_r <= flashResetN ? 8'h00 : ((&loCnt_r) ? loCnt_r : loCnt_r + 8'h01);
            hiCnt_r <= !flashResetN ? 8'h00 : ((&hiCnt_r) ? hiCnt_r : hiCnt_r + 8'h01);
            unCnt_r <= !unprotLevelEn ? 24'h000000 : ((&unCnt_r) ? unCnt_r : unCnt_r + 24'h000001);
        end
    end
    chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_reset_width: assert property ($rose(flashResetN) |-> loCnt_r >= 8'h7d)
        else $error("reset pulse short");
    chk_read_recovery: assert property ($fell(flashOeN) |-> hiCnt_r >= 8'h0d)
        else $error("read too soon after reset");
    chk_unprot_setup: assert property ($fell(flashWeN) && unprotLevelEn |-> unCnt_r >= RSP_CYC)
        else $error("write too soon after unprotect level");
    chk_write_ready: assert property ($fell(flashWeN) |-> readyBusyN)
        else $error("write while device busy");
    chk_bus_contention: assert property (!(flashDqOe && !flashOeN))
        else $error("data bus driven during read");
    chk_strobe_exclusive: assert property (flashOeN || flashWeN)
        else $error("read and write strobes together");
    cov_reset_release: cover property ($rose(flashResetN));
    cov_write_strobe: cover property ($fell(flashWeN));
    cov_unprot_write: cover property ($fell(flashWeN) && unprotLevelEn);
endmodule // nfc_host_checker
bind nfc_host nfc_host_checker #(.READY_CYC(READY_CYC), .RSP_CYC(RSP_CYC)) u_nfc_host_checker
    (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
     .flashOeN(flashOeN), .flashWeN(flashWeN), .flashResetN(flashResetN),
     .unprotLevelEn(unprotLevelEn), .flashDqOe(flashDqOe), .readyBusyN(readyBusyN));

// >>> sim/nfc_flash_model.sv
// Purpose: Behavioural NOR flash seen from its pins
// Assumes: Counts delays on the bench clock
// Notes:   Every write starts a program; no command decode
`timescale 1ns/10ps
module nfc_flash_model
#(
    parameter int         PROG_CYC  = 2250,
    parameter int         ABORT_CYC = 2500,
    parameter int         SBY_CYC   = 5000,
    parameter logic [7:0] SUSP_SECT = 8'h12
)
(
    input  wire logic        clk_sys,
    input  wire logic        ceN,
    input  wire logic        oeN,
    input  wire logic        weN,
    input  wire logic        resetN,
    input  wire logic [19:0] addr,
    input  wire logic [15:0] dqOut,
    output logic      [15:0] dqIn,
    output logic             readyBusyN
);
    logic [15:0] mem_r    = 16'h0000;
    logic [15:0] held_r   = 16'h0000;
    logic [19:0] lastAddr = 20'h00000;
    int          busyCnt  = 0;
    int          lowCnt   = 0;
    int          writes   = 0;
    logic        weNd_r   = 1'b1;
    logic        rdNd_r   = 1'b1;
    logic        tog6_r   = 1'b0;
    logic        tog2_r   = 1'b0;
    logic        standby  = 1'b0;
    logic        rdN;
    logic [15:0] drv;
    // Busy status word while an algorithm runs
    assign rdN = ceN | oeN;
    assign readyBusyN = (busyCnt == 0);
    assign drv = (busyCnt != 0) ? {9'h000, tog6_r, 3'h0, tog2_r, 2'h0} : mem_r;
    // Released bus shows the inverse so stale data cannot pass
    assign dqIn = rdN ? ~held_r : drv;
    always @(posedge clk_sys)
    begin
        weNd_r <= weN;
        rdNd_r <= rdN;
        if (!rdN)
            held_r <= drv;
        if (!resetN)
        begin
            lowCnt <= lowCnt + 1;
            standby <= (lowCnt >= SBY_CYC);
            if (busyCnt > ABORT_CYC)
                busyCnt <= ABORT_CYC;
            else if (busyCnt != 0)
                busyCnt <= busyCnt - 1;
        end
        else
        begin
            lowCnt <= 0;
            standby <= 1'b0;
            // Byte-mode program time
            if (weN && !weNd_r)
            begin
                lastAddr <= addr;
                mem_r <= dqOut;
                writes <= writes + 1;
                busyCnt <= PROG_CYC;
            end
            else if (busyCnt != 0)
                busyCnt <= busyCnt - 1;
            if (!rdN && rdNd_r && busyCnt != 0)
            begin
                tog6_r <= ~tog6_r;
                if (addr[19:12] == SUSP_SECT)
                    tog2_r <= ~tog2_r;
            end
        end
    end
endmodule // nfc_flash_model

// >>> sim/test_nfc_host.sv
// Purpose: Self-checking bench for the NOR flash host controller
// Assumes: 250 MHz clk_sys, flash model on the pins
// Notes:   Registers reached by classic Wishbone cycles
`timescale 1ns/10ps
`include "nfc_defines.vh"
module test_nfc_host;
    localparam int PROG_CYC = 2250;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    wire  [31:0] wb_dat_o;
    wire  [19:0] flashAddr;
    wire  [15:0] flashDqOut, flashDqIn;
    wire         wb_ack_o, flashCeN, flashOeN, flashWeN, flashResetN, unprotLevelEn, readyBusyN;
    int          miscompares = 0;
    int          checks = 0;
    always #2 clk_sys = ~clk_sys;
    nfc_host u_nfc_host (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN),
        .flashResetN(flashResetN), .unprotLevelEn(unprotLevelEn), .flashAddr(flashAddr),
        .flashDqOut(flashDqOut), .flashDqOe(), .flashDqIn(flashDqIn), .readyBusyN(readyBusyN));
    nfc_flash_model u_nfc_flash_model (.clk_sys(clk_sys), .ceN(flashCeN), .oeN(flashOeN), .weN(flashWeN),
        .resetN(flashResetN), .addr(flashAddr), .dqOut(flashDqOut), .dqIn(flashDqIn), .readyBusyN(readyBusyN));
    task automatic complete_run;
        if (miscompares == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    // Request held until ack is sampled high
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // Bounded poll; the watchdog catches a hang
    task automatic wait_idle(output logic [31:0] q);
        int n;
        n = 0;
        do
        begin
            wb(1'b0, `NFC_REG_STATUS, 32'h00000000, q);
            n++;
        end
        while (q[0] !== 1'b0 && n < 5000);
        chk(q[0], 1'b0, "operation never finished");
    endtask
    task automatic run(input logic [31:0] c, output logic [31:0] q, output time dt);
        time t0;
        wb(1'b1, `NFC_REG_CTRL, c, q);
        t0 = $time;
        wait_idle(q);
        dt = $time - t0;
    endtask
    task automatic t_program;
        logic [31:0] q;
        time dt;
        int w0;
        w0 = u_nfc_flash_model.writes;
        wb(1'b1, `NFC_REG_ADDR, 32'h00012345, q);
        wb(1'b1, `NFC_REG_WDATA, 32'h0000a5c3, q);
        wb(1'b1, `NFC_REG_CTRL, 32'h00000003, q);
        repeat (100) @(posedge clk_sys);
        wb(1'b0, `NFC_REG_STATUS, 32'h00000000, q);
        chk(q[1:0], 2'b01, "busy state mid program");
        run(32'h00000003, q, dt);
        chk(dt >= (PROG_CYC - 100) * 4, 1'b1, "program done too early");
        chk(u_nfc_flash_model.writes - w0, 1, "second command while busy");
        chk(u_nfc_flash_model.lastAddr, 20'h12345, "program address");
        run(32'h00000001, q, dt);
        chk(q[31:16], 16'ha5c3, "read back");
    endtask
    task automatic t_toggle;
        logic [31:0] q;
        time dt;
        run(32'h00000041, q, dt);
        chk({q[4], q[2]}, 2'b01, "toggle by output enable");
        run(32'h000000c1, q, dt);
        chk({q[4], q[2]}, 2'b01, "toggle by chip select");
    endtask
    task automatic t_reset;
        logic [31:0] q;
        time dt;
        run(32'h00000005, q, dt);
        chk(dt >= 263 * 4, 1'b1, "reset sequence short");
        chk(flashResetN, 1'b1, "reset pin released");
        run(32'h00000001, q, dt);
        chk(q[31:16], 16'ha5c3, "read after reset");
        wb(1'b1, `NFC_REG_CTRL, 32'h00000003, q);
        repeat (100) @(posedge clk_sys);
        run(32'h00000005, q, dt);
        chk(dt >= (125 + 5000 + 13) * 4, 1'b1, "recovery after cut program short");
        chk(q[1:0], 2'b10, "ready and idle after cut program");
    endtask
    task automatic t_protect;
        logic [31:0] q;
        logic [31:0] codes[2] = '{32'h00000013, 32'h00000033};
        logic [2:0]  bits[2] = '{3'b010, 3'b110};
        time dt;
        for (int i = 0; i < 2; i++)
        begin
            run(codes[i], q, dt);
            chk({u_nfc_flash_model.lastAddr[6], u_nfc_flash_model.lastAddr[1:0]}, bits[i], "sector select");
        end
    endtask
    task automatic t_unprot;
        logic [31:0] q;
        time dt;
        run(32'h00000009, q, dt);
        chk(unprotLevelEn, 1'b1, "unprotect level on");
        chk(dt >= 1000 * 4, 1'b1, "unprotect setup short");
        run(32'h00000003, q, dt);
        run(32'h00000005, q, dt);
        chk(unprotLevelEn, 1'b0, "unprotect level cleared");
    endtask
    initial
    begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        t_program;
        t_toggle;
        t_reset;
        t_protect;
        t_unprot;
        complete_run;
    end
    // Whole run needs about 16k cycles
    initial
    begin
        #200000;
        miscompares++;
        complete_run;
    end
endmodule // test_nfc_host
